// ==== core/uart_mode_and_frame_control.v ====
/*
 Async serial unit top: APB register file, power/enable control, baud
 prescaler, transmit buffer, receive buffer and pin-function multiplexing.
 Assumes an APB master on pclk and serial_in_pin synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_mode_and_frame_control (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [15:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        serial_in_pin,
	output reg         serial_out_pin,
	output reg         serial_out_oe_n
);
	// Full-width reset words, cut to the stored fields on purpose
	localparam [7:0] CTRL_INIT = `CTRL_RST;
	localparam [7:0] PORT_INIT = `PORT_RST;
	reg  [7:0]  mode_q;
	reg  [5:0]  ctrl_q;
	reg         brk_trig_q;
	reg  [3:0]  cksel_q;
	reg  [7:0]  baud_q;
	reg  [2:0]  port_q;
	reg  [7:0]  txb_q;
	reg         txbf_q;
	reg         tx_load_q;
	reg  [7:0]  rxb_q;
	reg         rx_full_q;
	reg  [2:0]  rxerr_q;
	reg  [10:0] pre_cnt_q;
	reg         tick_q;
	reg         rxd_q;
	reg  [31:0] rdata_d;
	reg         hit_d;
	wire        ser_rst_n;
	wire        pwr;
	wire        tx_on;
	wire        rx_on;
	wire        acc;
	wire        wr;
	wire        rd;
	wire [3:0]  ck_sel;
	wire [10:0] pre_lim;
	wire        tx_line;
	wire        tx_busy;
	wire        rx_done;
	wire [7:0]  rx_data;
	wire        rx_perr;
	wire        rx_ferr;

	// Derived from a flop, so the serial reset cannot glitch on bus activity
	assign pwr       = mode_q[`MODE_POWER];
	assign ser_rst_n = presetn & pwr;
	assign tx_on     = pwr & mode_q[`MODE_TXE];
	assign rx_on     = pwr & mode_q[`MODE_RXE];

	// Zero-wait APB: answer stands in the first access cycle
	assign acc = psel & penable & pready;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	always @* begin
		rdata_d = 32'h0000_0000;
		hit_d   = 1'b1;
		case (paddr)
			`ADDR_MODE:   rdata_d[7:0] = mode_q;
			`ADDR_CTRL:   rdata_d[7:0] = {1'b0, 1'b0, ctrl_q};
			`ADDR_TXB:    rdata_d[7:0] = txb_q;
			`ADDR_RXB:    rdata_d[7:0] = rxb_q;
			`ADDR_RXERR:  rdata_d[2:0] = rxerr_q;
			`ADDR_TXSTAT: rdata_d[1:0] = {txbf_q, tx_busy};
			`ADDR_CKSEL:  rdata_d[3:0] = cksel_q;
			`ADDR_BAUD:   rdata_d[7:0] = baud_q;
			`ADDR_PORT:   rdata_d[3:0] = {serial_in_pin, port_q};
			default:      hit_d = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
			pslverr <= psel & ~penable & ~hit_d;
		end
	end

	// Configuration registers, reset only by the bus reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q  <= `MODE_RST;
			ctrl_q  <= CTRL_INIT[5:0];
			cksel_q <= `CKSEL_RST;
			baud_q  <= `BAUD_RST;
			port_q  <= PORT_INIT[2:0];
		end else if (wr) begin
			case (paddr)
				`ADDR_MODE:  mode_q  <= pwdata[7:0];
				`ADDR_CTRL:  ctrl_q  <= pwdata[5:0];
				`ADDR_CKSEL: cksel_q <= pwdata[3:0];
				`ADDR_BAUD:  baud_q  <= pwdata[7:0];
				`ADDR_PORT:  port_q  <= pwdata[2:0];
				default:     port_q  <= port_q;
			endcase
		end
	end

	// Break trigger has no engine here; it only reads back as zero
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n)
			brk_trig_q <= 1'b0;
		else if (wr && paddr == `ADDR_CTRL && rx_on)
			brk_trig_q <= pwdata[`CTRL_BRT];
	end

	// Prescaler; clock stops while powered down
	assign ck_sel  = (cksel_q > `CKSEL_MAX) ? `CKSEL_MAX : cksel_q;
	assign pre_lim = (11'h001 << ck_sel) - 11'h001;
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n) begin
			pre_cnt_q <= 11'h000;
			tick_q    <= 1'b0;
		end else if (pre_cnt_q >= pre_lim) begin
			pre_cnt_q <= 11'h000;
			tick_q    <= 1'b1;
		end else begin
			pre_cnt_q <= pre_cnt_q + 11'h001;
			tick_q    <= 1'b0;
		end
	end

	// Receive input view: forced high while the unit is off
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n)
			rxd_q <= 1'b1;
		else
			rxd_q <= rx_on ? serial_in_pin : 1'b1;
	end

	// Transmit buffer; a write while full overwrites, as the host is warned
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n) begin
			txb_q     <= 8'h00;
			txbf_q    <= 1'b0;
			tx_load_q <= 1'b0;
		end else if (!tx_on) begin
			txbf_q    <= 1'b0;
			tx_load_q <= 1'b0;
		end else begin
			tx_load_q <= txbf_q & ~tx_busy & ~tx_load_q;
			if (wr && paddr == `ADDR_TXB) begin
				txb_q  <= pwdata[7:0];
				txbf_q <= 1'b1;
			end else if (tx_load_q) begin
				txbf_q <= 1'b0;
			end
		end
	end

	// Receive buffer and error flags; a new error wins over the read clear
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n) begin
			rxb_q     <= `RXB_RST;
			rx_full_q <= 1'b0;
			rxerr_q   <= 3'h0;
		end else begin
			if (rx_done) begin
				rxb_q     <= rx_data;
				rx_full_q <= 1'b1;
			end else if (rd && paddr == `ADDR_RXB) begin
				rx_full_q <= 1'b0;
			end
			if (rx_done)
				rxerr_q <= rxerr_q | {rx_perr, rx_ferr, rx_full_q};
			else if (rd && paddr == `ADDR_RXERR)
				rxerr_q <= 3'h0;
		end
	end

	// Pin multiplexing: serial function or plain port latch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_pin  <= 1'b1;
			serial_out_oe_n <= 1'b1;
		end else if (tx_on) begin
			serial_out_pin  <= tx_line ^ ctrl_q[`CTRL_INV];
			serial_out_oe_n <= 1'b0;
		end else if (!pwr) begin
			serial_out_pin  <= port_q[`PORT_ODIR] ? 1'b1 : port_q[`PORT_OLAT];
			serial_out_oe_n <= port_q[`PORT_ODIR];
		end else begin
			serial_out_pin  <= port_q[`PORT_OLAT];
			serial_out_oe_n <= port_q[`PORT_ODIR];
		end
	end

	uart_tx u_tx (
		.pclk      (pclk),
		.ser_rst_n (ser_rst_n),
		.tx_on     (tx_on),
		.tick      (tick_q),
		.div       (baud_q),
		.par_mode  (mode_q[`MODE_PS_HI:`MODE_PS_LO]),
		.char8     (mode_q[`MODE_CL]),
		.stop2     (mode_q[`MODE_SL]),
		.lsb_first (ctrl_q[`CTRL_DIR]),
		.load      (tx_load_q),
		.data      (txb_q),
		.line      (tx_line),
		.busy      (tx_busy)
	);

	uart_rx u_rx (
		.pclk      (pclk),
		.ser_rst_n (ser_rst_n),
		.rx_on     (rx_on),
		.tick      (tick_q),
		.div       (baud_q),
		.par_mode  (mode_q[`MODE_PS_HI:`MODE_PS_LO]),
		.char8     (mode_q[`MODE_CL]),
		.lsb_first (ctrl_q[`CTRL_DIR]),
		.rxd       (rxd_q),
		.done_q    (rx_done),
		.data_q    (rx_data),
		.perr_q    (rx_perr),
		.ferr_q    (rx_ferr)
	);
endmodule // uart_mode_and_frame_control
`default_nettype wire

// ==== core/uart_core_consts.vh ====
/*
 Constants for the async serial unit: register byte addresses, reset values,
 field positions and parity codes. Assumes a 16-bit APB byte address.
*/
`ifndef UART_CORE_CONSTS_VH
`define UART_CORE_CONSTS_VH

`define ADDR_MODE   16'hFF50
`define ADDR_CTRL   16'hFF58
`define ADDR_TXB    16'hFF60
`define ADDR_RXB    16'hFF64
`define ADDR_RXERR  16'hFF68
`define ADDR_TXSTAT 16'hFF6C
`define ADDR_CKSEL  16'hFF70
`define ADDR_BAUD   16'hFF74
`define ADDR_PORT   16'hFF78

`define MODE_RST    8'h01
`define CTRL_RST    8'h16
`define RXB_RST     8'hFF
`define PORT_RST    8'h03
`define CKSEL_RST   4'h0
`define BAUD_RST    8'hFF
`define CKSEL_MAX   4'hA

`define MODE_POWER  7
`define MODE_TXE    6
`define MODE_RXE    5
`define MODE_PS_HI  4
`define MODE_PS_LO  3
`define MODE_CL     2
`define MODE_SL     1
`define CTRL_BRF    7
`define CTRL_BRT    6
`define CTRL_DIR    1
`define CTRL_INV    0
`define PORT_ODIR   0
`define PORT_IDIR   1
`define PORT_OLAT   2

`define PAR_NONE    2'h0
`define PAR_ZERO    2'h1
`define PAR_ODD     2'h2
`define PAR_EVEN    2'h3

`endif

// ==== core/uart_tx.v ====
/*
 Transmit framer: start, 7/8 data bits, optional parity, 1/2 stop bits.
 Assumes tick is a one-cycle prescaler enable and div counts ticks per bit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_tx (
	input  wire       pclk,
	input  wire       ser_rst_n,
	input  wire       tx_on,
	input  wire       tick,
	input  wire [7:0] div,
	input  wire [1:0] par_mode,
	input  wire       char8,
	input  wire       stop2,
	input  wire       lsb_first,
	input  wire       load,
	input  wire [7:0] data,
	output reg        line,
	output wire       busy
);
	localparam ST_IDLE = 3'h0, ST_START = 3'h1, ST_DATA = 3'h2;
	localparam ST_PAR = 3'h3, ST_STOP = 3'h4;
	reg [2:0] state_q;
	reg [7:0] cnt_q;
	reg [2:0] idx_q;
	reg [7:0] sh_q;
	reg       second_q;
	wire [7:0] div_m1 = (div == 8'h00) ? 8'h00 : div - 8'h01;
	wire       bit_end = tick && (cnt_q == div_m1);
	wire [2:0] last = char8 ? 3'h7 : 3'h6;
	wire [2:0] sel = lsb_first ? idx_q : last - idx_q;
	wire       par_bit = (par_mode == `PAR_EVEN) ? ^sh_q :
		(par_mode == `PAR_ODD) ? ~^sh_q : 1'b0;
	assign busy = (state_q != ST_IDLE);
	always @* begin
		case (state_q)
			ST_START: line = 1'b0;
			ST_DATA:  line = sh_q[sel];
			ST_PAR:   line = par_bit;
			default:  line = 1'b1;
		endcase
	end
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n) begin
			state_q  <= ST_IDLE;
			cnt_q    <= 8'h00;
			idx_q    <= 3'h0;
			sh_q     <= 8'h00;
			second_q <= 1'b0;
		end else if (!tx_on) begin
			state_q  <= ST_IDLE;
			cnt_q    <= 8'h00;
			second_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			if (load) begin
				sh_q    <= char8 ? data : {1'b0, data[6:0]};
				state_q <= ST_START;
				cnt_q   <= 8'h00;
				idx_q   <= 3'h0;
			end
		end else if (bit_end) begin
			cnt_q <= 8'h00;
			case (state_q)
				ST_START: state_q <= ST_DATA;
				ST_DATA: begin
					idx_q <= idx_q + 3'h1;
					if (idx_q == last) begin
						state_q  <= (par_mode == `PAR_NONE) ? ST_STOP : ST_PAR;
						second_q <= stop2;
					end
				end
				ST_PAR: state_q <= ST_STOP;
				default: begin
					if (second_q)
						second_q <= 1'b0;
					else
						state_q <= ST_IDLE;
				end
			endcase
		end else if (tick) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule // uart_tx
`default_nettype wire

// ==== core/uart_rx.v ====
/*
 Receive deframer: start edge detect, centre sampling, parity and stop check.
 Assumes rxd is already synchronous and idles high; tick as for transmit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_rx (
	input  wire       pclk,
	input  wire       ser_rst_n,
	input  wire       rx_on,
	input  wire       tick,
	input  wire [7:0] div,
	input  wire [1:0] par_mode,
	input  wire       char8,
	input  wire       lsb_first,
	input  wire       rxd,
	output reg        done_q,
	output reg  [7:0] data_q,
	output reg        perr_q,
	output reg        ferr_q
);
	localparam ST_IDLE = 3'h0, ST_START = 3'h1, ST_DATA = 3'h2;
	localparam ST_PAR = 3'h3, ST_STOP = 3'h4;
	reg [2:0] state_q;
	reg [7:0] cnt_q;
	reg [2:0] idx_q;
	reg       ones_q;
	reg       prev_q;
	wire [7:0] div_m1 = (div == 8'h00) ? 8'h00 : div - 8'h01;
	wire [2:0] last = char8 ? 3'h7 : 3'h6;
	wire [2:0] sel = lsb_first ? idx_q : last - idx_q;
	wire [7:0] half = {1'b0, div[7:1]};
	// One tick early: edge detection already costs a cycle
	wire       mid = tick && (cnt_q == ((half == 8'h00) ? 8'h00 : half - 8'h01));
	wire       smp = tick && (cnt_q == div_m1);
	always @(posedge pclk or negedge ser_rst_n) begin
		if (!ser_rst_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			idx_q   <= 3'h0;
			ones_q  <= 1'b0;
			prev_q  <= 1'b1;
			done_q  <= 1'b0;
			data_q  <= 8'h00;
			perr_q  <= 1'b0;
			ferr_q  <= 1'b0;
		end else if (!rx_on) begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			prev_q  <= 1'b1;
			done_q  <= 1'b0;
		end else begin
			prev_q <= rxd;
			done_q <= 1'b0;
			if (tick)
				cnt_q <= cnt_q + 8'h01;
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 8'h00;
					if (prev_q && !rxd)
						state_q <= ST_START;
				end
				ST_START: if (mid) begin
					cnt_q   <= 8'h00;
					idx_q   <= 3'h0;
					ones_q  <= 1'b0;
					data_q  <= 8'h00;
					state_q <= rxd ? ST_IDLE : ST_DATA;
				end
				ST_DATA: if (smp) begin
					cnt_q        <= 8'h00;
					data_q[sel]  <= rxd;
					ones_q       <= ones_q ^ rxd;
					idx_q        <= idx_q + 3'h1;
					if (idx_q == last)
						state_q <= (par_mode == `PAR_NONE) ? ST_STOP : ST_PAR;
				end
				ST_PAR: if (smp) begin
					cnt_q   <= 8'h00;
					ones_q  <= ones_q ^ rxd;
					state_q <= ST_STOP;
				end
				ST_STOP: if (smp) begin
					done_q  <= 1'b1;
					ferr_q  <= !rxd;
					perr_q  <= ((par_mode == `PAR_EVEN) && ones_q) ||
						((par_mode == `PAR_ODD) && !ones_q);
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // uart_rx
`default_nettype wire

// ==== testbench/uart_frame_checker_asserts.sv ====
/*
 Checker for the async serial unit: APB answer timing and pin rules.
 Assumes it is bound to the top module; shadows the mode and port writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_frame_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [15:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_out_pin,
	input wire logic        serial_out_oe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] mode_q;
	logic       odir_q;
	logic       acc;
	logic       mapped;
	logic       on;
	assign acc = psel && penable && pready;
	assign on = mode_q[`MODE_POWER] && mode_q[`MODE_TXE];
	assign mapped = paddr inside {`ADDR_MODE, `ADDR_CTRL, `ADDR_TXB, `ADDR_RXB,
		`ADDR_RXERR, `ADDR_TXSTAT, `ADDR_CKSEL, `ADDR_BAUD, `ADDR_PORT};
	// Shadow only what the pin rules and the mode read check depend on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `MODE_RST;
			odir_q <= 1'b1;
		end else if (acc && pwrite && paddr == `ADDR_MODE) begin
			mode_q <= pwdata[7:0];
		end else if (acc && pwrite && paddr == `ADDR_PORT) begin
			odir_q <= pwdata[`PORT_ODIR];
		end
	end
	mode_read_a: assert property (acc && !pwrite && paddr == `ADDR_MODE |-> prdata == {24'h0, mode_q})
		else $error("mode register read differs from written value");
	ready_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer in the cycle after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	idle_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside access cycle");
	slverr_map_a: assert property (acc |-> pslverr == !mapped)
		else $error("error response does not match address map");
	ctrl_read_a: assert property (acc && !pwrite && paddr == `ADDR_CTRL |-> prdata[31:6] == 26'h0)
		else $error("break bits or upper bits read nonzero");
	off_high_a: assert property (!mode_q[7] && odir_q && !$past(mode_q[7]) && $past(odir_q) |-> serial_out_pin)
		else $error("serial output not high while powered off");
	tx_pin_a: assert property (on && $past(on) |-> !serial_out_oe_n)
		else $error("serial output not driven while transmit enabled");
	cover property (acc && pslverr);
	cover property (acc && pwrite && paddr == `ADDR_TXB && on);
	cover property ($fell(mode_q[`MODE_POWER]));
endmodule // uart_frame_checker
`default_nettype wire

// ==== testbench/uart_peer.sv ====
/*
 Remote serial peer: sends frames to the unit and decodes its output.
 Assumes bit time in pclk cycles; the input line idles high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_peer #(
	parameter int BIT = 4
) (
	input  wire logic pclk,
	input  wire logic line_in,
	output var  logic line_out
);
	initial line_out = 1'b1;
	task automatic put(input logic b);
		line_out <= b;
		repeat (BIT) @(posedge pclk);
	endtask
	// Bad flips the parity bit on purpose
	task automatic send(input logic [7:0] m, input logic [1:0] c, input logic [7:0] d,
		input logic bad);
		int n;
		n = m[`MODE_CL] ? 8 : 7;
		d = m[`MODE_CL] ? d : {1'b0, d[6:0]};
		put(1'b0);
		for (int i = 0; i < n; i++) put(c[1] ? d[i] : d[n - 1 - i]);
		if (m[4:3] != `PAR_NONE) put((m[4] & (^d ^ ~m[3])) ^ bad);
		repeat (m[`MODE_SL] ? 2 : 1) put(1'b1);
	endtask
	task automatic recv(input logic [7:0] m, input logic [1:0] c, output logic [7:0] d,
		output logic p, output logic s);
		int n;
		n = m[`MODE_CL] ? 8 : 7;
		d = 8'h00;
		p = 1'b0;
		// Idle first: a port-mode pin may sit low before transmit is enabled
		while ((line_in ^ c[0]) !== 1'b1) @(posedge pclk);
		while ((line_in ^ c[0]) !== 1'b0) @(posedge pclk);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			repeat (BIT) @(posedge pclk);
			d[c[1] ? i : n - 1 - i] = line_in ^ c[0];
		end
		if (m[4:3] != `PAR_NONE) begin
			repeat (BIT) @(posedge pclk);
			p = line_in ^ c[0];
		end
		repeat (BIT) @(posedge pclk);
		s = line_in ^ c[0];
	endtask
endmodule // uart_peer
`default_nettype wire

// ==== testbench/uart_mode_and_frame_control_tb.sv ====
/*
 Self-checking bench: APB tasks, one frame per parity mode both ways.
 Assumes the peer model on the serial pins and the shared constants.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_mode_and_frame_control_tb;
	localparam int BIT = 4;
	localparam logic [13:0] frames [4] = '{{4'hE, 2'h2, 8'h55}, {4'h9, 2'h2, 8'h36},
		{4'h6, 2'h1, 8'hA5}, {4'h3, 2'h0, 8'h87}};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        serial_in_pin, serial_out_pin, serial_out_oe_n, er, pb, sb;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  m, d, k, q;
	logic [1:0]  c;
	int          failures, checks;
	uart_mode_and_frame_control uart_mode_and_frame_control_inst (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.serial_out_oe_n(serial_out_oe_n));
	uart_peer #(.BIT(BIT)) uart_peer_inst (.pclk(pclk), .line_in(serial_out_pin),
		.line_out(serial_in_pin));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] v);
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, v};
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait limit here; the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		apb(a, 1'b1, v);
	endtask
	task automatic rdc(input string s, input logic [15:0] a, input logic [31:0] e);
		apb(a, 1'b0, 8'h00);
		chk(s, e, rd);
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_of_test();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("mode", `ADDR_MODE, 32'h01);
		rdc("ctrl", `ADDR_CTRL, 32'h16);
		apb(16'hFF5C, 1'b1, 8'h00);
		chk("slverr", 32'h1, {31'h0, er});
		chk("pin", 32'h1, {31'h0, serial_out_pin});
		wr(`ADDR_CKSEL, 8'h00);
		wr(`ADDR_BAUD, 8'(BIT));
		foreach (frames[i]) begin
			m = {3'h0, frames[i][13:10], 1'b0};
			c = frames[i][9:8];
			d = frames[i][7:0];
			k = m[2] ? 8'hFF : 8'h7F;
			wr(`ADDR_MODE, m);
			wr(`ADDR_CTRL, {6'h0, c});
			wr(`ADDR_MODE, m | 8'h80);
			wr(`ADDR_MODE, m | 8'hE0);
			fork
				wr(`ADDR_TXB, d);
				uart_peer_inst.recv(m, c, q, pb, sb);
				uart_peer_inst.send(m, c, ~d, 1'b1);
			join
			chk("tx byte", {24'h0, d & k}, {24'h0, q});
			chk("tx parity", {31'h0, m[4] & (^(d & k) ^ ~m[3])}, {31'h0, pb});
			chk("tx stop", 32'h1, {31'h0, sb});
			rdc("rx byte", `ADDR_RXB, {24'h0, ~d & k});
			rdc("rx error", `ADDR_RXERR, {29'h0, m[4], 2'h0});
			wr(`ADDR_MODE, m | 8'h80);
		end
		wr(`ADDR_MODE, m | 8'hA0);
		uart_peer_inst.send(m, 2'h0, 8'h3C, 1'b0);
		uart_peer_inst.send(m, 2'h0, 8'hC3, 1'b0);
		rdc("rx last", `ADDR_RXB, 32'hC3);
		rdc("rx overrun", `ADDR_RXERR, 32'h1);
		wr(`ADDR_MODE, m | 8'h80);
		wr(`ADDR_MODE, m);
		rdc("rx off", `ADDR_RXB, 32'hFF);
		rdc("err off", `ADDR_RXERR, 32'h0);
		rdc("tx off", `ADDR_TXSTAT, 32'h0);
		chk("pin off", 32'h1, {31'h0, serial_out_pin});
		end_of_test();
	end
endmodule // uart_mode_and_frame_control_tb
bind uart_mode_and_frame_control uart_frame_checker uart_frame_checker_inst (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n));
`default_nettype wire
